// ===== tb_top.sv
// Self-checking testbench of the external bus controller.
// Assumes the memory model answers on the bus pins; configuration is driven as plain ports.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import xbc_pkg::*;
  logic clk_sys, reset, req_valid, req_write, req_word;
  logic [23:0] req_addr;
  logic [15:0] req_wdata, rsp_rdata, sys_cfg, dflt, w1, w2, w3, w4, apo, dpo, dpi, ale_a, rd;
  logic [3:0][15:0] wsel;
  logic req_ready, rsp_valid, apoe, ale, rd_n, wr_n, bhe_n, stb_bhe;
  logic [5:0] sao, saoe, ale_seg;
  logic [1:0] dpoe;
  logic [3:0] cs_n, pre_cs, ale_cs, stb_cs;
  logic [3:0][5:0] sp_exp;
  int miscompares, cmp_count, ale_cnt, stb_cnt, lat;

  xbc_ext_bus_ctrl u_xbc_ext_bus_ctrl (
    .clk_sys(clk_sys), .reset(reset), .req_valid(req_valid), .req_addr(req_addr),
    .req_write(req_write), .req_word(req_word), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .system_config_reg(sys_cfg), .default_bus_config_reg(dflt),
    .first_window_config(w1), .second_window_config(w2), .third_window_config(w3),
    .fourth_window_config(w4), .window_select_reg(wsel), .address_port_out(apo),
    .address_port_oe(apoe), .seg_addr_out(sao), .seg_addr_oe(saoe), .data_port_in(dpi),
    .data_port_out(dpo), .data_port_oe(dpoe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .bhe_n(bhe_n), .cs_n(cs_n)
  );

  xbc_mem_model u_xbc_mem_model (
    .clk_sys(clk_sys), .address_port_out(apo), .address_port_oe(apoe),
    .data_port_out(dpo), .data_port_oe(dpoe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .data_port_in(dpi)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Records the first address phase and strobe of each access, and counts all its ALE and strobe cycles.
  always @(posedge clk_sys) begin
    if (ale) begin
      if (ale_cnt == 0) begin
        ale_a = apoe ? apo : dpo;
        ale_seg = sao;
        ale_cs = cs_n;
      end
      ale_cnt++;
    end
    if (!rd_n || !wr_n) begin
      if (stb_cnt == 0) begin
        stb_cs = cs_n;
        stb_bhe = bhe_n;
      end
      stb_cnt++;
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out;
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [15:0] mk(input logic wide, input logic mux, input logic [2:0] opt,
                                     input logic [3:0] wt);
    logic [15:0] c;
    c = 16'h0000;
    c[CFG_EN_BIT] = 1'b1;
    c[CFG_WIDE_BIT] = wide;
    c[CFG_MUX_BIT] = mux;
    c[CFG_RWD_BIT] = opt[2];
    c[CFG_ALE_BIT] = opt[1];
    c[CFG_TRI_BIT] = opt[0];
    c[CFG_WAIT_LSB +: CFG_WAIT_W] = wt;
    return c;
  endfunction

  // Cycles from the taking edge to the response for a given set and part count.
  function automatic int xl(input logic [15:0] c, input int parts);
    return parts * ((c[CFG_ALE_BIT] ? 2 : 1) + int'(c[CFG_RWD_BIT]) + int'(c[3:0]) + 1
                    + int'(c[CFG_TRI_BIT])) + 1;
  endfunction

  // Entered just after a rising edge; returns one cycle after the response edge.
  task automatic op(input logic w, input logic wd, input logic [23:0] a, input logic [15:0] d);
    int n;
    ale_cnt = 0;
    stb_cnt = 0;
    req_addr = a;
    req_write = w;
    req_word = wd;
    req_wdata = d;
    req_valid = 1'b1;
    #1 pre_cs = cs_n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1 n++;
    end
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    lat = 1;
    while (rsp_valid !== 1'b1 && lat < 100) begin
      @(posedge clk_sys);
      #1 lat++;
    end
    rd = rsp_rdata;
    @(posedge clk_sys);
    #1;
  endtask

  initial begin
    #100000;
    miscompares++;
    close_out;
  end

  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req_addr = 24'h000000;
    req_write = 1'b0;
    req_word = 1'b0;
    req_wdata = 16'h0000;
    sys_cfg = 16'h3000;
    dflt = mk(1'b1, 1'b0, 3'h0, 4'h0);
    {w1, w2, w3, w4} = 64'h0;
    wsel = {4{16'h1000}};
    sp_exp = {6'h3f, 6'h0f, 6'h03, 6'h00};
    miscompares = 0;
    cmp_count = 0;
    ale_cnt = 0;
    stb_cnt = 0;
    repeat (10) @(posedge clk_sys);
    #1 chk("reset_pins", 8'hef, {req_ready, rd_n, wr_n, ale, cs_n});
    reset = 1'b0;
    @(posedge clk_sys);
    #1 op(1'b1, 1'b1, 24'h200124, 16'ha55a);
    chk("lat_demux", xl(dflt, 1), lat);
    chk("addr_demux", 16'h0124, ale_a);
    chk("seg_addr", 6'h20, ale_seg);
    chk("cs_dflt", 4'he, ale_cs);
    chk("cs_before", 4'hf, pre_cs);
    chk("cs_strobe", 4'he, stb_cs);
    chk("bhe_word", 1'b0, stb_bhe);
    op(1'b0, 1'b1, 24'h200124, 16'h0000);
    chk("rd_word", 16'ha55a, rd);
    op(1'b1, 1'b0, 24'h200125, 16'h0077);
    op(1'b0, 1'b0, 24'h200125, 16'h0000);
    chk("rd_byte", 16'h0077, rd);
    dflt = mk(1'b1, 1'b0, 3'h7, 4'h3);
    op(1'b0, 1'b1, 24'h200124, 16'h0000);
    chk("lat_opts", xl(dflt, 1), lat);
    chk("ale_len", 2, ale_cnt);
    chk("strobe_len", 4, stb_cnt);
    chk("rd_opts", 16'h775a, rd);
    dflt = mk(1'b0, 1'b1, 3'h0, 4'h1);
    op(1'b1, 1'b1, 24'h200201, 16'hc33c);
    chk("lat_mux2", xl(dflt, 2), lat);
    chk("addr_mux", 16'h0201, ale_a);
    chk("strobes_mux", 4, stb_cnt);
    chk("bhe_narrow", 1'b1, stb_bhe);
    op(1'b0, 1'b1, 24'h200201, 16'h0000);
    chk("rd_mux", 16'hc33c, rd);
    op(1'b0, 1'b0, 24'h200202, 16'h0000);
    chk("rd_mux_b", 16'h00c3, rd);
    chk("lat_mux1", xl(dflt, 1), lat);
    dflt = mk(1'b1, 1'b1, 3'h0, 4'h0);
    op(1'b0, 1'b1, 24'h200124, 16'h0000);
    chk("rd_mux16", 16'h775a, rd);
    chk("addr_mux16", 16'h0124, ale_a);
    chk("lat_mux16", xl(dflt, 1), lat);
    dflt = mk(1'b0, 1'b0, 3'h0, 4'h0);
    op(1'b0, 1'b1, 24'h200124, 16'h0000);
    chk("rd_demux8", 16'h775a, rd);
    chk("lat_demux8", xl(dflt, 2), lat);
    dflt[CFG_EN_BIT] = 1'b0;
    op(1'b0, 1'b1, 24'h200124, 16'h0000);
    chk("single_chip", {8'h01, 8'h00, 16'h0000}, {lat[7:0], ale_cnt[7:0], rd});
    dflt = mk(1'b1, 1'b0, 3'h0, 4'h0);
    op(1'b1, 1'b1, 24'h00f600, 16'h1234);
    chk("iram", {8'h01, 8'h00}, {lat[7:0], ale_cnt[7:0]});
    op(1'b0, 1'b1, 24'h00fe00, 16'h0000);
    chk("sfr", {8'h01, 8'h00}, {lat[7:0], ale_cnt[7:0]});
    w1 = mk(1'b1, 1'b0, 3'h0, 4'h1);
    w2 = mk(1'b1, 1'b0, 3'h0, 4'h2);
    op(1'b0, 1'b1, 24'h100010, 16'h0000);
    chk("cs_w2", 4'hb, ale_cs);
    chk("lat_w2", xl(w2, 1), lat);
    w3 = mk(1'b1, 1'b0, 3'h0, 4'h4);
    w4 = mk(1'b1, 1'b0, 3'h0, 4'h5);
    op(1'b0, 1'b1, 24'h100010, 16'h0000);
    chk("cs_w4", 4'hf, ale_cs);
    chk("lat_w4", xl(w4, 1), lat);
    w4 = 16'h0000;
    op(1'b0, 1'b1, 24'h100010, 16'h0000);
    chk("cs_w3", 4'h7, ale_cs);
    chk("lat_w3", xl(w3, 1), lat);
    op(1'b0, 1'b1, 24'h101010, 16'h0000);
    chk("cs_out", 4'he, ale_cs);
    chk("lat_out", xl(dflt, 1), lat);
    sys_cfg[SYS_UNLATCH_BIT] = 1'b1;
    op(1'b0, 1'b1, 24'h100010, 16'h0000);
    chk("cs_unlatched", 4'h7, pre_cs);
    sys_cfg[SYS_UNLATCH_BIT] = 1'b0;
    for (int i = 0; i < 4; i++) begin
      sys_cfg[SYS_SPACE_LSB +: 2] = 2'(i);
      repeat (2) @(posedge clk_sys);
      #1 chk("seg_oe", sp_exp[i], saoe);
    end
    close_out;
  end
endmodule // tb_top

`default_nettype wire

// ===== xbc_ext_bus_ctrl.sv
// External bus controller: turns CPU accesses into external bus cycles.
// Assumes synchronous pins, a requester that holds its request until req_ready.
`timescale 1ns/1ps
`default_nettype none

module xbc_ext_bus_ctrl
  import xbc_pkg::*;
#(
  parameter logic LARGE_VARIANT = 1'b1,
  parameter logic [XBC_AW-1:0] IRAM_LO = 24'h00f600,
  parameter logic [XBC_AW-1:0] IRAM_HI = 24'h00fdff,
  parameter logic [XBC_AW-1:0] SFR_LO = 24'h00fe00,
  parameter logic [XBC_AW-1:0] SFR_HI = 24'h00ffff,
  parameter logic ROM_EN = 1'b0,
  parameter logic [XBC_AW-1:0] ROM_LO = 24'h000000,
  parameter logic [XBC_AW-1:0] ROM_HI = 24'h007fff
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic [XBC_AW-1:0] req_addr,
  input wire logic req_write,
  input wire logic req_word,
  input wire logic [XBC_DW-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [XBC_DW-1:0] rsp_rdata,
  input wire logic [15:0] system_config_reg,
  input wire logic [15:0] default_bus_config_reg,
  input wire logic [15:0] first_window_config,
  input wire logic [15:0] second_window_config,
  input wire logic [15:0] third_window_config,
  input wire logic [15:0] fourth_window_config,
  input wire logic [XBC_NWIN-1:0][15:0] window_select_reg,
  output logic [15:0] address_port_out,
  output logic address_port_oe,
  output logic [XBC_SEGW-1:0] seg_addr_out,
  output logic [XBC_SEGW-1:0] seg_addr_oe,
  input wire logic [XBC_DW-1:0] data_port_in,
  output logic [XBC_DW-1:0] data_port_out,
  output logic [1:0] data_port_oe,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic bhe_n,
  output logic [XBC_NCS-1:0] cs_n
);

  function automatic logic in_range(input logic [XBC_AW-1:0] a, input logic [XBC_AW-1:0] lo,
                                    input logic [XBC_AW-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // Active-high select vector for a decoded window; windows without a pin select nothing.
  function automatic logic [XBC_NCS-1:0] cs_of(input logic [2:0] hit);
    logic [XBC_NCS-1:0] v;
    v = '0;
    if (hit == 3'h0) begin
      v[0] = 1'b1;
    end else if (hit == 3'h1) begin
      v[1] = 1'b1;
    end else if (LARGE_VARIANT && hit < 3'h4) begin
      v[hit[1:0]] = 1'b1;
    end
    return v;
  endfunction

  xbc_state_type state_reg, state_next;
  logic [XBC_AW-1:0] addr_reg, addr_next;
  logic write_reg, write_next, word_reg, word_next, part_reg, part_next, two_reg, two_next;
  logic [XBC_DW-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [15:0] cfg_reg, cfg_next;
  logic [CFG_WAIT_W-1:0] cnt_reg, cnt_next;
  logic rsp_reg, rsp_next;
  logic [XBC_NCS-1:0] cs_latch_reg, cs_latch_next;
  logic ale_reg, ale_next, rd_n_reg, rd_n_next, wr_n_reg, wr_n_next, bhe_n_reg, bhe_n_next;
  logic [15:0] aport_reg, aport_next;
  logic aport_oe_reg, aport_oe_next;
  logic [XBC_SEGW-1:0] seg_reg, seg_next, seg_oe_reg, seg_oe_next;
  logic [XBC_DW-1:0] dout_reg, dout_next;
  logic [1:0] doe_reg, doe_next;
  logic ext_en, unlatched, internal_hit, start_ext, part_end;
  logic [1:0] space;
  logic [7:0] rbyte;
  logic [XBC_NCS-1:0] live_cs;

  xbc_win_if win_if ();
  xbc_window_decode u_decode (.win(win_if.decoder));

  assign ext_en = default_bus_config_reg[CFG_EN_BIT];
  assign unlatched = system_config_reg[SYS_UNLATCH_BIT];
  assign space = system_config_reg[SYS_SPACE_LSB +: 2];
  assign internal_hit = in_range(req_addr, IRAM_LO, IRAM_HI) ||
                        in_range(req_addr, SFR_LO, SFR_HI) ||
                        (ROM_EN && in_range(req_addr, ROM_LO, ROM_HI));
  assign start_ext = req_valid && ext_en && !internal_hit;

  assign win_if.sel_reg = window_select_reg;
  assign win_if.win_cfg = {fourth_window_config, third_window_config,
                           second_window_config, first_window_config};
  assign win_if.dflt_cfg = default_bus_config_reg;
  assign win_if.addr = (state_reg == ST_IDLE) ? req_addr : addr_reg;

  // Unlatched selects follow the live address; latched ones hold the value caught at start.
  assign live_cs = ((state_reg != ST_IDLE) || start_ext) ? cs_of(win_if.hit) : '0;
  assign cs_n = ~(unlatched ? live_cs : cs_latch_reg);

  assign req_ready = (state_reg == ST_IDLE);
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;
  assign address_port_out = aport_reg;
  assign address_port_oe = aport_oe_reg;
  assign seg_addr_out = seg_reg;
  assign seg_addr_oe = seg_oe_reg;
  assign data_port_out = dout_reg;
  assign data_port_oe = doe_reg;
  assign ale = ale_reg;
  assign rd_n = rd_n_reg;
  assign wr_n = wr_n_reg;
  assign bhe_n = bhe_n_reg;

  // Byte that the current part reads: the high lane for an odd address on a 16-bit bus, else the low lane.
  assign rbyte = (cfg_reg[CFG_WIDE_BIT] && addr_reg[0]) ? data_port_in[15:8] : data_port_in[7:0];

  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    write_next = write_reg;
    word_next = word_reg;
    part_next = part_reg;
    two_next = two_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    cfg_next = cfg_reg;
    cnt_next = cnt_reg;
    cs_latch_next = cs_latch_reg;
    rsp_next = 1'b0;
    part_end = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_ext) begin
          addr_next = req_addr;
          write_next = req_write;
          word_next = req_word;
          wdata_next = req_wdata;
          cfg_next = win_if.cfg;
          cs_latch_next = cs_of(win_if.hit);
          part_next = 1'b0;
          two_next = req_word && (!win_if.cfg[CFG_WIDE_BIT] || req_addr[0]);
          rdata_next = '0;
          cnt_next = win_if.cfg[CFG_ALE_BIT] ? CFG_WAIT_W'(1) : '0;
          state_next = ST_ALE;
        end else if (req_valid) begin
          rdata_next = '0;
          rsp_next = 1'b1;
        end
      end
      ST_ALE: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - CFG_WAIT_W'(1);
        end else if (cfg_reg[CFG_RWD_BIT]) begin
          state_next = ST_DELAY;
        end else begin
          cnt_next = cfg_reg[CFG_WAIT_LSB +: CFG_WAIT_W];
          state_next = ST_STROBE;
        end
      end
      ST_DELAY: begin
        cnt_next = cfg_reg[CFG_WAIT_LSB +: CFG_WAIT_W];
        state_next = ST_STROBE;
      end
      ST_STROBE: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - CFG_WAIT_W'(1);
        end else begin
          if (!write_reg) begin
            if (two_reg) begin
              if (part_reg) begin
                rdata_next[15:8] = rbyte;
              end else begin
                rdata_next[7:0] = rbyte;
              end
            end else if (word_reg) begin
              rdata_next = data_port_in;
            end else begin
              rdata_next = {8'h00, rbyte};
            end
          end
          if (cfg_reg[CFG_TRI_BIT]) begin
            state_next = ST_HOLD;
          end else begin
            part_end = 1'b1;
          end
        end
      end
      ST_HOLD: part_end = 1'b1;
      default: state_next = ST_IDLE;
    endcase
    if (part_end) begin
      if (two_reg && !part_reg) begin
        part_next = 1'b1;
        addr_next = addr_reg + XBC_AW'(1);
        cnt_next = cfg_reg[CFG_ALE_BIT] ? CFG_WAIT_W'(1) : '0;
        state_next = ST_ALE;
      end else begin
        rsp_next = 1'b1;
        cs_latch_next = '0;
        state_next = ST_IDLE;
      end
    end
  end

  // Pin values for the next cycle, taken from the next state so pins come from flops.
  always_comb begin
    ale_next = (state_next == ST_ALE);
    rd_n_next = !((state_next == ST_STROBE) && !write_next);
    wr_n_next = !((state_next == ST_STROBE) && write_next);
    aport_next = addr_next[15:0];
    aport_oe_next = (state_next != ST_IDLE) && !cfg_next[CFG_MUX_BIT];
    seg_next = addr_next[XBC_SEG_LSB +: XBC_SEGW];
    seg_oe_next = ext_en ? xbc_seg_mask(space) : SEG_NONE;
    bhe_n_next = !((state_next != ST_IDLE) && cfg_next[CFG_WIDE_BIT] &&
                   ((word_next && !two_next) || addr_next[0]));
    dout_next = dout_reg;
    doe_next = LANE_NONE;
    if (state_next == ST_ALE && cfg_next[CFG_MUX_BIT]) begin
      dout_next = addr_next[15:0];
      doe_next = cfg_next[CFG_WIDE_BIT] ? LANE_BOTH : LANE_LOW;
    end else if ((state_next == ST_DELAY || state_next == ST_STROBE) && write_next) begin
      if (!cfg_next[CFG_WIDE_BIT]) begin
        dout_next = {8'h00, part_next ? wdata_next[15:8] : wdata_next[7:0]};
        doe_next = LANE_LOW;
      end else if (word_next && !two_next) begin
        dout_next = wdata_next;
        doe_next = LANE_BOTH;
      end else begin
        dout_next = part_next ? {wdata_next[15:8], wdata_next[15:8]} :
                                {wdata_next[7:0], wdata_next[7:0]};
        doe_next = addr_next[0] ? LANE_HIGH : LANE_LOW;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      addr_reg <= '0;
      write_reg <= 1'b0;
      word_reg <= 1'b0;
      part_reg <= 1'b0;
      two_reg <= 1'b0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      cfg_reg <= '0;
      cnt_reg <= '0;
      rsp_reg <= 1'b0;
      cs_latch_reg <= '0;
      ale_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      bhe_n_reg <= 1'b1;
      aport_reg <= '0;
      aport_oe_reg <= 1'b0;
      seg_reg <= '0;
      seg_oe_reg <= SEG_NONE;
      dout_reg <= '0;
      doe_reg <= LANE_NONE;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      write_reg <= write_next;
      word_reg <= word_next;
      part_reg <= part_next;
      two_reg <= two_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      cfg_reg <= cfg_next;
      cnt_reg <= cnt_next;
      rsp_reg <= rsp_next;
      cs_latch_reg <= cs_latch_next;
      ale_reg <= ale_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      bhe_n_reg <= bhe_n_next;
      aport_reg <= aport_next;
      aport_oe_reg <= aport_oe_next;
      seg_reg <= seg_next;
      seg_oe_reg <= seg_oe_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  single_chip_a: assert property ((!ext_en && req_valid && req_ready) |=>
      (rsp_valid && ale == 1'b0 && rd_n && wr_n)) else $error("bus moved in single-chip");
  internal_a: assert property ((req_valid && req_ready && internal_hit) |=>
      (rsp_valid && !ale && req_ready)) else $error("internal address reached the bus");
  demux_addr_a: assert property (((!rd_n || !wr_n) && !cfg_reg[CFG_MUX_BIT]) |->
      (address_port_oe && address_port_out == addr_reg[15:0])) else $error("no demux address");
  narrow_lane_a: assert property ((data_port_oe != LANE_NONE && !cfg_reg[CFG_WIDE_BIT]) |->
      data_port_oe == LANE_LOW) else $error("8-bit bus drove high lane");
  mux_addr_a: assert property ((ale && cfg_reg[CFG_MUX_BIT]) |->
      (data_port_out == addr_reg[15:0] && data_port_oe != LANE_NONE)) else $error("no mux address");
  ale_long_a: assert property (($rose(ale) && cfg_reg[CFG_ALE_BIT]) |->
      ale [*2] ##1 !ale) else $error("long latch pulse wrong length");
  strobe_short_a: assert property (($fell(rd_n) && cfg_reg[CFG_WAIT_LSB +: CFG_WAIT_W] == '0 &&
      !cfg_reg[CFG_TRI_BIT]) |=> rd_n) else $error("zero-wait strobe too long");
  cs_onehot_a: assert property ($onehot0(~cs_n)) else $error("several selects active");
  small_cs_a: assert property (!LARGE_VARIANT |-> cs_n[3:2] == 2'b11)
    else $error("small variant drove upper selects");
  cs_stable_a: assert property ((!unlatched && !$past(unlatched) && state_reg != ST_IDLE &&
      $past(state_reg) != ST_IDLE) |-> $stable(cs_n)) else $error("latched select moved");
  seg_full_a: assert property ((ext_en && space == SPACE_4M) |=>
      seg_addr_oe == SEG_ALL) else $error("full space lacks segment lines");
  seg_none_a: assert property ((ext_en && space == SPACE_64K) |=>
      seg_addr_oe == SEG_NONE) else $error("64K space drove segment lines");

endmodule // xbc_ext_bus_ctrl

`default_nettype wire

// ===== xbc_mem_model.sv
// Behavioural external memory on the far side of the bus controller.
// Assumes pins sampled on clk_sys; storage keyed by the low nine address bits.
`timescale 1ns/1ps
`default_nettype none

module xbc_mem_model (
  input wire logic clk_sys,
  input wire logic [15:0] address_port_out,
  input wire logic address_port_oe,
  input wire logic [15:0] data_port_out,
  input wire logic [1:0] data_port_oe,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [15:0] data_port_in
);
  logic [7:0] mem [0:511];
  logic [8:0] la;
  logic [15:0] rword;
  logic [15:0] last;

  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'h00;
    last = 16'h0000;
  end

  // The low lane carries the byte at the latched address, the high lane the odd byte of its pair.
  assign rword = {mem[la | 9'h001], mem[la]};
  // Outside a read strobe the lines show the inverse of the last value, so no stale match.
  assign data_port_in = !rd_n ? rword : ~last;

  // Multiplexed cycles carry the address on the data port while the address port is off.
  always @(posedge clk_sys) begin
    if (ale) la <= address_port_oe ? address_port_out[8:0] : data_port_out[8:0];
    if (!rd_n) last <= rword;
    if (!wr_n && data_port_oe[0]) mem[la] <= data_port_out[7:0];
    if (!wr_n && data_port_oe[1]) mem[la | 9'h001] <= data_port_out[15:8];
  end
endmodule // xbc_mem_model

`default_nettype wire

// ===== xbc_pkg.sv
// Shared constants, field layouts and types of the external bus controller.
// Assumes one synchronous clock domain; all configuration arrives as plain ports.
`default_nettype none

package xbc_pkg;

  localparam int XBC_AW = 24;
  localparam int XBC_DW = 16;
  localparam int XBC_NWIN = 4;
  localparam int XBC_NCS = 4;
  localparam int XBC_SEGW = 6;
  localparam int XBC_SEG_LSB = 16;
  localparam int XBC_GRAN_BITS = 12;

  // Bus configuration register layout (default and window sets).
  localparam int CFG_WAIT_LSB = 0;
  localparam int CFG_WAIT_W = 4;
  localparam int CFG_TRI_BIT = 4;
  localparam int CFG_ALE_BIT = 5;
  localparam int CFG_RWD_BIT = 6;
  localparam int CFG_MUX_BIT = 7;
  localparam int CFG_WIDE_BIT = 8;
  localparam int CFG_EN_BIT = 9;

  // Window select register layout.
  localparam int SEL_SIZE_LSB = 0;
  localparam int SEL_SIZE_W = 4;
  localparam int SEL_BASE_LSB = 4;
  localparam int SEL_BASE_W = 12;

  // System configuration register layout.
  localparam int SYS_UNLATCH_BIT = 6;
  localparam int SYS_SPACE_LSB = 12;
  localparam logic [1:0] SPACE_64K = 2'h0;
  localparam logic [1:0] SPACE_256K = 2'h1;
  localparam logic [1:0] SPACE_1M = 2'h2;
  localparam logic [1:0] SPACE_4M = 2'h3;

  localparam logic [5:0] SEG_NONE = 6'h00;
  localparam logic [5:0] SEG_TWO = 6'h03;
  localparam logic [5:0] SEG_FOUR = 6'h0f;
  localparam logic [5:0] SEG_ALL = 6'h3f;

  localparam logic [1:0] LANE_NONE = 2'h0;
  localparam logic [1:0] LANE_LOW = 2'h1;
  localparam logic [1:0] LANE_HIGH = 2'h2;
  localparam logic [1:0] LANE_BOTH = 2'h3;

  typedef enum logic [2:0] {ST_IDLE, ST_ALE, ST_DELAY, ST_STROBE, ST_HOLD} xbc_state_type;

  // Segment lines driven for each restricted address space.
  function automatic logic [5:0] xbc_seg_mask(input logic [1:0] space);
    case (space)
      SPACE_64K: return SEG_NONE;
      SPACE_256K: return SEG_TWO;
      SPACE_1M: return SEG_FOUR;
      default: return SEG_ALL;
    endcase
  endfunction

endpackage

`default_nettype wire

// ===== xbc_win_if.sv
// Interface between the controller and its address window decoder.
// Assumes the user side drives address and configuration, the decoder the result.
`timescale 1ns/1ps
`default_nettype none

interface xbc_win_if;
  import xbc_pkg::*;
  logic [XBC_NWIN-1:0][15:0] sel_reg;
  logic [XBC_NWIN-1:0][15:0] win_cfg;
  logic [15:0] dflt_cfg;
  logic [XBC_AW-1:0] addr;
  logic [2:0] hit;
  logic [15:0] cfg;
  modport decoder(input sel_reg, input win_cfg, input dflt_cfg, input addr,
                  output hit, output cfg);
  modport user(output sel_reg, output win_cfg, output dflt_cfg, output addr,
               input hit, input cfg);
endinterface

`default_nettype wire

// ===== xbc_window_decode.sv
// Address window decoder: picks the bus configuration that governs an address.
// Assumes stable window registers; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module xbc_window_decode
  import xbc_pkg::*;
(
  xbc_win_if.decoder win
);

  function automatic logic win_match(input logic [15:0] sel, input logic [XBC_AW-1:0] a);
    logic [SEL_BASE_W-1:0] mask;
    mask = {SEL_BASE_W{1'b1}} << sel[SEL_SIZE_LSB +: SEL_SIZE_W];
    return ((a[XBC_AW-1:XBC_GRAN_BITS] ^ sel[SEL_BASE_LSB +: SEL_BASE_W]) & mask) == '0;
  endfunction

  // Later windows are tested last so that they override earlier ones.
  always_comb begin
    win.hit = 3'h0;
    win.cfg = win.dflt_cfg;
    for (int i = 0; i < XBC_NWIN; i++) begin
      if (win.win_cfg[i][CFG_EN_BIT] && win_match(win.sel_reg[i], win.addr)) begin
        win.hit = 3'(i + 1);
        win.cfg = win.win_cfg[i];
      end
    end
  end

endmodule // xbc_window_decode

`default_nettype wire
